// File: common/rcp_defines.svh
// Timing counts and field positions for the remote-control pin logic.
// Assumes a 250 MHz sys_clk; all counts are derived from printed times.
// Operation
// - Each status line can serve as a button or contact input or as an output to circuitry.
// - Status lines zero to three are outputs while the low group direction pin is low, else inputs.
// - Status lines four to seven are outputs while the high group direction pin is low, else inputs.
// - A low power-down pin puts the block in a dead low-power state; the outside holds it high.
// - With latch select high each activation toggles an output; low, an output follows valid reception.
// - A low reset pin resets the block; the outside keeps it high in normal use.
// - The receive amplifier enable is high whenever the block is receiving.
// - The transmit amplifier enable is high whenever the block is transmitting.
// - An acknowledgement is sent after a valid control message only when acknowledge enable is high.
// - A high pairing request starts pairing, after which the two units accept each other.
// - A special sequence on the pairing request restores the factory default configuration.
// - Acknowledge received goes high when an acknowledgement arrives after a sent control message.
// - The activity indicator flashes, with a flash length that encodes the current state.
// - Each acknowledgement holds acknowledge received for 100 ms and a further one restarts it.
// - A status input high on the initiating unit drives the same output high on the responder.
`ifndef RCP_DEFINES_SVH
`define RCP_DEFINES_SVH
`define RCP_CLK_MHZ 250
`define RCP_ACK_HOLD_MS 100
`define RCP_ACK_HOLD_CYCLES (`RCP_ACK_HOLD_MS * 1000 * `RCP_CLK_MHZ)
`define RCP_FLASH_SHORT_MS 50
`define RCP_FLASH_SHORT_CYCLES (`RCP_FLASH_SHORT_MS * 1000 * `RCP_CLK_MHZ)
`define RCP_FACTORY_PULSES 4
`define RCP_FACTORY_GAP_MS 1000
`define RCP_FACTORY_GAP_CYCLES (`RCP_FACTORY_GAP_MS * 1000 * `RCP_CLK_MHZ)
`define RCP_LINES 8
`define RCP_GROUP 4
`endif

// File: common/rcp_pkg.sv
// Types shared by the remote-control pin logic files.
// Assumes rcp_defines.svh for the numeric constants.
package rcp_pkg;
    typedef enum logic [2:0] {
        RCP_OFF = 3'b000,
        RCP_IDLE = 3'b001,
        RCP_RX = 3'b010,
        RCP_TX = 3'b011,
        RCP_ACK_TX = 3'b100,
        RCP_PAIR = 3'b101
    } rcp_state_type;
    typedef struct packed {
        logic [7:0] lines;
        logic valid;
        logic ack;
    } rcp_msg_type;
endpackage

// File: hdl/rcp_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs.
// Assumes inputs change with no relation to sys_clk.
`timescale 1ns/1ps
module rcp_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] next_stage;
    logic [WIDTH-1:0] next_sync_out;

    always_comb
    begin
        next_stage = async_in;
        next_sync_out = stage;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            stage <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage <= next_stage;
            sync_out <= next_sync_out;
        end
    end
endmodule

// File: hdl/rcp_pin_logic.sv
// Pin-level control of the hopping remote-control transceiver.
// Assumes the radio core supplies decoded messages and accepts send requests on sys_clk.
`timescale 1ns/1ps
`include "rcp_defines.svh"
module rcp_pin_logic #(
    parameter int ACK_HOLD_CYCLES = `RCP_ACK_HOLD_CYCLES,
    parameter int FLASH_CYCLES = `RCP_FLASH_SHORT_CYCLES,
    parameter int FACTORY_GAP_CYCLES = `RCP_FACTORY_GAP_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Pins from the outside
    input wire logic power_down_n,
    input wire logic reset_n,
    input wire logic low_group_direction,
    input wire logic high_group_direction,
    input wire logic latch_select,
    input wire logic ack_enable,
    input wire logic pair_request,
    // Status lines, three signals each
    input wire logic [7:0] status_line_in,
    output logic [7:0] status_line_out,
    output logic [7:0] status_line_oe,
    // Radio core side
    input wire logic radio_receiving,
    input wire logic radio_transmitting,
    input wire rcp_pkg::rcp_msg_type radio_rx,
    output rcp_pkg::rcp_msg_type radio_tx,
    output logic send_ack,
    output logic pair_start,
    output logic factory_reset,
    // Status pins
    output logic receive_amplifier_enable,
    output logic transmit_amplifier_enable,
    output logic ack_received,
    output logic activity_indicator
);
    localparam int NSYNC = 15;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] syn;
    logic [7:0] lines_s;
    logic pd_n_s, rst_n_s, dir_lo_s, dir_hi_s, latch_s, acken_s, pair_s;
    logic [7:0] dir_out;
    logic halt;

    assign raw = {pair_request, ack_enable, latch_select, high_group_direction,
                  low_group_direction, reset_n, power_down_n, status_line_in};

    rcp_sync #(.WIDTH(NSYNC)) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(raw),
        .sync_out(syn)
    );

    assign lines_s = syn[7:0];
    assign pd_n_s = syn[8];
    assign rst_n_s = syn[9];
    assign dir_lo_s = syn[10];
    assign dir_hi_s = syn[11];
    assign latch_s = syn[12];
    assign acken_s = syn[13];
    assign pair_s = syn[14];
    // Reset only counts once synchronised; the idle value of the synchroniser is low, so
    // the block stays held until both pins have been seen high.
    assign halt = !pd_n_s || !rst_n_s;

    // A line drives only when its group is strapped as output.
    genvar g;
    generate
        for (g = 0; g < `RCP_LINES; g++)
        begin : g_dir
            if (g < `RCP_GROUP)
            begin : g_lo
                assign dir_out[g] = !dir_lo_s;
            end
            else
            begin : g_hi
                assign dir_out[g] = !dir_hi_s;
            end
        end
    endgenerate

    // Output line state.
    logic [7:0] out_q, next_out_q, oe_q, next_oe_q, drv_q, next_drv_q;
    logic [7:0] prev_cmd, next_prev_cmd;
    always_comb
    begin
        next_out_q = out_q;
        next_prev_cmd = prev_cmd;
        next_oe_q = dir_out;
        if (halt)
        begin
            next_out_q = '0;
            next_prev_cmd = '0;
        end
        else if (latch_s)
        begin
            if (radio_rx.valid && !radio_rx.ack)
            begin
                // Toggle on each fresh activation only, so a held button toggles once.
                next_out_q = out_q ^ (radio_rx.lines & ~prev_cmd);
                next_prev_cmd = radio_rx.lines;
            end
        end
        else if (radio_rx.valid && !radio_rx.ack)
        begin
            next_out_q = radio_rx.lines;
            next_prev_cmd = radio_rx.lines;
        end
        else if (!radio_receiving)
        begin
            next_out_q = '0;
            next_prev_cmd = '0;
        end
        // The pin value is registered on its own so the output comes straight from a flop.
        next_drv_q = next_out_q & next_oe_q;
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            out_q <= '0;
            oe_q <= '0;
            drv_q <= '0;
            prev_cmd <= '0;
        end
        else
        begin
            out_q <= next_out_q;
            oe_q <= next_oe_q;
            drv_q <= next_drv_q;
            prev_cmd <= next_prev_cmd;
        end
    end
    assign status_line_out = drv_q;
    assign status_line_oe = oe_q;

    // Transmit request: input lines are sampled and handed to the core.
    rcp_pkg::rcp_msg_type tx_q, next_tx_q;
    logic ack_q, next_ack_q;
    always_comb
    begin
        next_tx_q.lines = lines_s & ~dir_out;
        next_tx_q.valid = !halt && |(lines_s & ~dir_out);
        next_tx_q.ack = 1'b0;
        next_ack_q = !halt && acken_s && radio_rx.valid && !radio_rx.ack;
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tx_q <= '0;
            ack_q <= 1'b0;
        end
        else
        begin
            tx_q <= next_tx_q;
            ack_q <= next_ack_q;
        end
    end
    assign radio_tx = tx_q;
    assign send_ack = ack_q;

    // Amplifier enables.
    logic lna_q, pa_q, next_lna_q, next_pa_q;
    always_comb
    begin
        next_lna_q = !halt && radio_receiving;
        next_pa_q = !halt && radio_transmitting;
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            lna_q <= 1'b0;
            pa_q <= 1'b0;
        end
        else
        begin
            lna_q <= next_lna_q;
            pa_q <= next_pa_q;
        end
    end
    assign receive_amplifier_enable = lna_q;
    assign transmit_amplifier_enable = pa_q;

    // Acknowledge received hold timer.
    logic sent_q, next_sent_q;
    logic [31:0] ack_cnt, next_ack_cnt;
    logic ackr_q, next_ackr_q;
    always_comb
    begin
        next_sent_q = sent_q;
        next_ack_cnt = ack_cnt;
        if (halt)
        begin
            next_sent_q = 1'b0;
            next_ack_cnt = '0;
        end
        else
        begin
            if (tx_q.valid)
            begin
                next_sent_q = 1'b1;
            end
            if (sent_q && radio_rx.valid && radio_rx.ack)
            begin
                next_ack_cnt = 32'(ACK_HOLD_CYCLES);
            end
            else if (ack_cnt != '0)
            begin
                next_ack_cnt = ack_cnt - 32'h0000_0001;
            end
        end
        next_ackr_q = (next_ack_cnt != '0);
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sent_q <= 1'b0;
            ack_cnt <= '0;
            ackr_q <= 1'b0;
        end
        else
        begin
            sent_q <= next_sent_q;
            ack_cnt <= next_ack_cnt;
            ackr_q <= next_ackr_q;
        end
    end
    assign ack_received = ackr_q;

    // Pairing and factory-default detection by counting rising edges in a window.
    logic pair_d, next_pair_d;
    logic [31:0] gap_cnt, next_gap_cnt;
    logic [3:0] pulses, next_pulses;
    logic pstart_q, next_pstart_q, fact_q, next_fact_q;
    always_comb
    begin
        next_pair_d = pair_s;
        next_gap_cnt = gap_cnt;
        next_pulses = pulses;
        next_pstart_q = 1'b0;
        next_fact_q = 1'b0;
        if (halt)
        begin
            next_gap_cnt = '0;
            next_pulses = '0;
        end
        else if (pair_s && !pair_d)
        begin
            next_pstart_q = 1'b1;
            next_gap_cnt = 32'(FACTORY_GAP_CYCLES);
            if (pulses == 4'(`RCP_FACTORY_PULSES - 1))
            begin
                next_fact_q = 1'b1;
                next_pulses = '0;
            end
            else
            begin
                next_pulses = pulses + 4'h1;
            end
        end
        else if (gap_cnt != '0)
        begin
            next_gap_cnt = gap_cnt - 32'h0000_0001;
        end
        else
        begin
            next_pulses = '0;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pair_d <= 1'b0;
            gap_cnt <= '0;
            pulses <= '0;
            pstart_q <= 1'b0;
            fact_q <= 1'b0;
        end
        else
        begin
            pair_d <= next_pair_d;
            gap_cnt <= next_gap_cnt;
            pulses <= next_pulses;
            pstart_q <= next_pstart_q;
            fact_q <= next_fact_q;
        end
    end
    assign pair_start = pstart_q;
    assign factory_reset = fact_q;

    // Activity indicator: short flash per period in receive, long in transmit, steady in pair.
    logic [31:0] fl_cnt, next_fl_cnt;
    logic ind_q, next_ind_q;
    logic [31:0] on_len;
    always_comb
    begin
        on_len = radio_transmitting ? 32'(2 * FLASH_CYCLES) : 32'(FLASH_CYCLES);
        next_fl_cnt = (fl_cnt >= 32'(4 * FLASH_CYCLES - 1)) ? '0 : fl_cnt + 32'h0000_0001;
        if (halt)
        begin
            next_fl_cnt = '0;
            next_ind_q = 1'b0;
        end
        else if (pulses != '0)
        begin
            next_ind_q = 1'b1;
        end
        else if (radio_transmitting || radio_receiving)
        begin
            next_ind_q = (fl_cnt < on_len);
        end
        else
        begin
            next_ind_q = 1'b0;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            fl_cnt <= '0;
            ind_q <= 1'b0;
        end
        else
        begin
            fl_cnt <= next_fl_cnt;
            ind_q <= next_ind_q;
        end
    end
    assign activity_indicator = ind_q;
endmodule

// File: tb/rcp_monitor.sv
// Port-level checker for the remote-control pin logic.
// Assumes it is bound into rcp_pin_logic with the same hold count.
`timescale 1ns/1ps
module rcp_monitor #(
    parameter int ACK_HOLD_CYCLES = 20
) (
    // Clock, reset and pins
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic power_down_n,
    input wire logic reset_n,
    input wire logic low_group_direction,
    input wire logic high_group_direction,
    input wire logic ack_enable,
    // Radio core and outputs
    input wire logic radio_receiving,
    input wire logic radio_transmitting,
    input wire rcp_pkg::rcp_msg_type radio_rx,
    input wire logic [7:0] status_line_out,
    input wire logic [7:0] status_line_oe,
    input wire logic send_ack,
    input wire logic receive_amplifier_enable,
    input wire logic transmit_amplifier_enable,
    input wire logic ack_received,
    input wire logic activity_indicator
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Cycles since the last acknowledgement; saturates so it never wraps.
    int gap;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            gap <= 1000;
        else if (radio_rx.valid && radio_rx.ack)
            gap <= 0;
        else if (gap < 1000)
            gap <= gap + 1;
    end
    property p_rx_amp;
        receive_amplifier_enable |-> $past(radio_receiving);
    endproperty
    a_rx_amp: assert property (p_rx_amp) else $error("rx amp on without receive");
    property p_tx_amp;
        transmit_amplifier_enable |-> $past(radio_transmitting);
    endproperty
    a_tx_amp: assert property (p_tx_amp) else $error("tx amp on without transmit");
    property p_pd_halt;
        !power_down_n [*4] |=> !(receive_amplifier_enable || transmit_amplifier_enable
            || ack_received || activity_indicator);
    endproperty
    a_pd_halt: assert property (p_pd_halt) else $error("output active in power down");
    property p_rst_halt;
        !reset_n [*4] |=> !(receive_amplifier_enable || transmit_amplifier_enable
            || ack_received || activity_indicator);
    endproperty
    a_rst_halt: assert property (p_rst_halt) else $error("output active in reset");
    property p_low_in;
        low_group_direction [*4] |=> status_line_oe[3:0] == 4'h0;
    endproperty
    a_low_in: assert property (p_low_in) else $error("low group driven as input");
    property p_high_in;
        high_group_direction [*4] |=> status_line_oe[7:4] == 4'h0;
    endproperty
    a_high_in: assert property (p_high_in) else $error("high group driven as input");
    property p_drive;
        (status_line_out & ~status_line_oe) == 8'h00;
    endproperty
    a_drive: assert property (p_drive) else $error("line high while not driven");
    property p_ack_send;
        send_ack |-> $past(radio_rx.valid && !radio_rx.ack) && $past(ack_enable, 3);
    endproperty
    a_ack_send: assert property (p_ack_send) else $error("ack sent without cause");
    property p_ack_rise;
        $rose(ack_received) |-> $past(radio_rx.valid && radio_rx.ack);
    endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("ack out rose without ack");
    property p_ack_hold;
        $fell(ack_received) && power_down_n && reset_n |-> gap >= ACK_HOLD_CYCLES;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack out dropped early");
endmodule

// File: tb/rcp_lines.sv
// Buttons, contacts and loads on the eight status lines.
// Assumes the block drives a line only while its enable is high.
`timescale 1ns/1ps
module rcp_lines (
    // Block side
    input wire logic [7:0] status_line_out,
    input wire logic [7:0] status_line_oe,
    // Bench side
    input wire logic [7:0] press,
    output logic [7:0] status_line_in
);
    // Released buttons sit on a pull-down, so an undriven line reads low.
    assign status_line_in = (status_line_oe & status_line_out) | (~status_line_oe & press);
endmodule

// File: tb/rcp_pin_logic_test.sv
// Self-checking bench for the remote-control pin logic.
// Assumes short hold, flash and gap counts so the run stays brief.
`timescale 1ns/1ps
module rcp_pin_logic_test;
    localparam int HOLD = 20;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic power_down_n = 1'b1;
    logic reset_n = 1'b1;
    logic low_group_direction = 1'b0;
    logic high_group_direction = 1'b1;
    logic latch_select = 1'b0;
    logic ack_enable = 1'b0;
    logic pair_request = 1'b0;
    logic radio_receiving = 1'b0;
    logic radio_transmitting = 1'b0;
    rcp_pkg::rcp_msg_type radio_rx = '0;
    rcp_pkg::rcp_msg_type radio_tx;
    logic [7:0] press = 8'h00;
    logic [7:0] status_line_in, status_line_out, status_line_oe, r;
    logic send_ack, pair_start, factory_reset, receive_amplifier_enable;
    logic transmit_amplifier_enable, ack_received, activity_indicator;
    int fail_count = 0;
    int n_compared = 0;
    int n;
    initial forever #2 sys_clk = ~sys_clk;
    rcp_pin_logic #(.ACK_HOLD_CYCLES(HOLD), .FLASH_CYCLES(4), .FACTORY_GAP_CYCLES(50))
    rcp_pin_logic_i (.sys_clk, .sys_rst, .power_down_n, .reset_n, .low_group_direction,
        .high_group_direction, .latch_select, .ack_enable, .pair_request, .status_line_in,
        .status_line_out, .status_line_oe, .radio_receiving, .radio_transmitting, .radio_rx,
        .radio_tx, .send_ack, .pair_start, .factory_reset, .receive_amplifier_enable,
        .transmit_amplifier_enable, .ack_received, .activity_indicator);
    rcp_lines rcp_lines_i (.status_line_out, .status_line_oe, .press, .status_line_in);
    function automatic logic [7:0] exp_oe(input logic lo, input logic hi);
        return {{4{~hi}}, {4{~lo}}};
    endfunction
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    // Holds valid for one edge and then drops it; the caller waits before the next message so they never merge.
    task automatic rx(input logic [7:0] lines, input logic ack);
        radio_rx = '{lines, 1'b1, ack};
        cyc(1);
        radio_rx.valid = 1'b0;
    endtask
    initial
    begin
        void'($urandom(32'h6cb7));
        cyc(20);
        sys_rst = 1'b0;
        cyc(4);
        for (int i = 0; i < 4; i++)
        begin
            {high_group_direction, low_group_direction} = 2'(i);
            cyc(5);
            chk("oe", status_line_oe, exp_oe(low_group_direction, high_group_direction));
        end
        {high_group_direction, low_group_direction} = 2'b10;
        cyc(5);
        radio_receiving = 1'b1;
        r = 8'($urandom);
        rx(r, 1'b0);
        chk("momentary", status_line_out, r & 8'h0f);
        chk("lna", 8'(receive_amplifier_enable), 8'h01);
        radio_receiving = 1'b0;
        cyc(3);
        chk("momentary_off", status_line_out, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            ack_enable = 1'($urandom);
            // The strap passes the pin synchroniser before the block acts on it.
            cyc(3);
            rx(8'h00, 1'(i % 2));
            chk("send_ack", 8'(send_ack), 8'(ack_enable && i % 2 == 0));
            chk("ack_early", 8'(ack_received), 8'h00);
            cyc(1);
        end
        latch_select = 1'b1;
        cyc(3);
        for (int i = 0; i < 3; i++)
        begin
            rx(i == 1 ? 8'h04 : (i == 0 ? 8'h05 : 8'h01), 1'b0);
            chk("latch", status_line_out, i == 2 ? 8'h04 : 8'h05);
            cyc(1);
        end
        press = 8'($urandom) | 8'h10;
        cyc(5);
        chk("tx_lines", 8'(radio_tx.lines[7:4]), 8'(press[7:4]));
        chk("tx_valid", 8'(radio_tx.valid), 8'h01);
        press = 8'h00;
        radio_transmitting = 1'b1;
        cyc(2);
        chk("pa", 8'(transmit_amplifier_enable), 8'h01);
        n = 0;
        while (activity_indicator !== 1'b1 && n < 40)
        begin
            cyc(1);
            n++;
        end
        if (n == 40)
        begin
            fail_count++;
            results();
        end
        rx(8'h00, 1'b1);
        chk("ack_out", 8'(ack_received), 8'h01);
        cyc(8);
        rx(8'h00, 1'b1);
        n = 0;
        while (ack_received === 1'b1 && n < 40)
        begin
            cyc(1);
            n++;
        end
        chk("ack_hold", 8'(n), 8'(HOLD));
        for (int i = 0; i < 2; i++)
        begin
            radio_receiving = 1'b1;
            rx(8'h00, 1'b1);
            {power_down_n, reset_n} = i ? 2'b10 : 2'b01;
            cyc(6);
            chk("halt", 8'({receive_amplifier_enable, transmit_amplifier_enable,
                ack_received, activity_indicator}), 8'h00);
            {power_down_n, reset_n} = 2'b11;
            cyc(5);
        end
        radio_receiving = 1'b0;
        radio_transmitting = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            pair_request = 1'b1;
            r = 8'h00;
            repeat (8)
            begin
                cyc(1);
                r = r | {6'h00, factory_reset, pair_start};
            end
            chk("pair", 8'(r[0]), 8'h01);
            chk("factory", 8'(r[1]), 8'(i == 3));
            chk("ind_pair", 8'(activity_indicator), 8'(i != 3));
            pair_request = 1'b0;
            cyc(4);
        end
        results();
    end
endmodule
bind rcp_pin_logic rcp_monitor #(.ACK_HOLD_CYCLES(ACK_HOLD_CYCLES)) rcp_monitor_i (.sys_clk,
    .sys_rst, .power_down_n, .reset_n, .low_group_direction, .high_group_direction,
    .ack_enable, .radio_receiving, .radio_transmitting, .radio_rx, .status_line_out,
    .status_line_oe, .send_ack, .receive_amplifier_enable, .transmit_amplifier_enable,
    .ack_received, .activity_indicator);
